// File: alp_defs.vh
`ifndef ALP_DEFS_VH
`define ALP_DEFS_VH

// Clock and sequencing times
`define ALP_CLK_MHZ 200
`define ALP_DWELL_MS 125
`define ALP_DWELL_CYC (`ALP_DWELL_MS * 1000 * `ALP_CLK_MHZ)
`define ALP_DWELL_W 25

// Sequencer states, each held for one dwell time
`define ALP_ST_FLASH 3'h0
`define ALP_ST_PWM_RST 3'h1
`define ALP_ST_LVL_RST 3'h2
`define ALP_ST_MEASURE 3'h3
`define ALP_ST_LAST 3'h7

// Light level and PWM widths
`define ALP_LVL_W 8
`define ALP_PWM_W 8
`define ALP_OSC_MAX 8'hFF

// Two-wire slave
`define ALP_I2C_ADDR 7'h2A
`define ALP_I2C_BITS 4'h8
`define ALP_I2_IDLE 3'h0
`define ALP_I2_ADDR 3'h1
`define ALP_I2_ACK 3'h2
`define ALP_I2_TX 3'h3
`define ALP_I2_MACK 3'h4
`define ALP_I2_RX 3'h5

`endif

// File: alp_led_pwm.v
`include "alp_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module alp_led_pwm #(
  parameter PWM_W = `ALP_PWM_W,
  parameter DWELL_CYC = `ALP_DWELL_CYC,
  parameter [6:0] I2C_ADDR = `ALP_I2C_ADDR
) (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Sensor oscillator and hold button
  input wire osc_in,
  input wire hold_button_n,
  // LED bias and drive
  output reg led_sense_en_r,
  output reg led_pwm_r,
  output reg led_mirror_r,
  // Light level display
  output reg [7:0] display_r,
  // Two-wire bus
  input wire scl_in,
  input wire sda_in,
  output reg sda_out_r,
  output reg sda_oe_r,
  // Indicator driven over the bus
  output reg gpio_out_r
);

  // ==========================================================
  // Helpers
  // ==========================================================
  localparam [31:0] DWELL_FULL = DWELL_CYC - 1;
  localparam [`ALP_DWELL_W-1:0] DWELL_LAST = DWELL_FULL[`ALP_DWELL_W-1:0];

  // Sequencer states
  localparam [2:0] ST_FLASH = `ALP_ST_FLASH;
  localparam [2:0] ST_PWM_RST = `ALP_ST_PWM_RST;
  localparam [2:0] ST_LVL_RST = `ALP_ST_LVL_RST;
  localparam [2:0] ST_MEASURE = `ALP_ST_MEASURE;
  localparam [2:0] ST_LAST = `ALP_ST_LAST;
  // Two-wire slave states
  localparam [2:0] I2_IDLE = `ALP_I2_IDLE;
  localparam [2:0] I2_ADDR = `ALP_I2_ADDR;
  localparam [2:0] I2_ACK = `ALP_I2_ACK;
  localparam [2:0] I2_TX = `ALP_I2_TX;
  localparam [2:0] I2_MACK = `ALP_I2_MACK;
  localparam [2:0] I2_RX = `ALP_I2_RX;

  function sum_carry_out;
    input [PWM_W-1:0] phase;
    input [PWM_W-1:0] level;
    reg [PWM_W:0] sum;
    begin
      sum = {1'b0, phase} + {1'b0, level} + {{PWM_W{1'b0}}, 1'b1};
      sum_carry_out = sum[PWM_W];
    end
  endfunction

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  reg osc_m_r, osc_s_r, osc_d_r;
  reg hold_m_r, hold_s_r;
  reg scl_m_r, scl_s_r, scl_d_r;
  reg sda_m_r, sda_s_r, sda_d_r;
  // Reset to idle levels so no false edge follows reset

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      osc_m_r <= 1'b0;
      osc_s_r <= 1'b0;
      osc_d_r <= 1'b0;
      hold_m_r <= 1'b1;
      hold_s_r <= 1'b1;
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      osc_m_r <= osc_in;
      osc_s_r <= osc_m_r;
      osc_d_r <= osc_s_r;
      hold_m_r <= hold_button_n;
      hold_s_r <= hold_m_r;
      scl_m_r <= scl_in;
      scl_s_r <= scl_m_r;
      scl_d_r <= scl_s_r;
      sda_m_r <= sda_in;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
    end
  end

  wire hold = ~hold_s_r;
  wire osc_rise = osc_s_r & ~osc_d_r;

  // ==========================================================
  // Sequencer: flash, phase reset, level reset, measure, dark
  // ==========================================================
  reg [2:0] state_r;
  reg [`ALP_DWELL_W-1:0] dwell_r;
  wire dwell_end = (dwell_r == DWELL_LAST);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_FLASH;
      dwell_r <= {`ALP_DWELL_W{1'b0}};
    end else if (hold) begin
      // Hold pins the sequencer in the flash state
      state_r <= ST_FLASH;
      dwell_r <= {`ALP_DWELL_W{1'b0}};
    end else if (dwell_end) begin
      dwell_r <= {`ALP_DWELL_W{1'b0}};
      state_r <= (state_r == ST_LAST) ? ST_FLASH : state_r + 3'h1;
    end else begin
      dwell_r <= dwell_r + {{(`ALP_DWELL_W-1){1'b0}}, 1'b1};
    end
  end

  // ==========================================================
  // Light measurement
  // ==========================================================
  reg [7:0] oscillation_counter;
  reg [7:0] light_level_register;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      oscillation_counter <= 8'h00;
      light_level_register <= 8'h00;
    end else begin
      if (state_r == ST_LVL_RST) begin
        oscillation_counter <= 8'h00;
      end else if (state_r == ST_MEASURE && osc_rise && !hold &&
                   oscillation_counter != `ALP_OSC_MAX) begin
        // Count stops at all ones rather than wrapping
        oscillation_counter <= oscillation_counter + 8'h01;
      end
      // Level is latched once per measurement, never while held
      if (state_r == ST_MEASURE && dwell_end && !hold) begin
        light_level_register <= oscillation_counter;
      end
    end
  end

  // ==========================================================
  // PWM
  // ==========================================================
  reg [PWM_W-1:0] pwm_phase_counter;
  wire [PWM_W-1:0] level = light_level_register[7 -: PWM_W];
  wire pwm_bit = sum_carry_out(pwm_phase_counter, level);
  wire lit = (state_r == ST_FLASH) & pwm_bit;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pwm_phase_counter <= {PWM_W{1'b0}};
      led_pwm_r <= 1'b0;
      led_mirror_r <= 1'b0;
      led_sense_en_r <= 1'b0;
      display_r <= 8'h00;
    end else begin
      // Phase keeps running in hold so the held level keeps its duty
      if (state_r == ST_PWM_RST) begin
        pwm_phase_counter <= {PWM_W{1'b0}};
      end else begin
        pwm_phase_counter <= pwm_phase_counter + {{(PWM_W-1){1'b0}}, 1'b1};
      end
      led_pwm_r <= lit;
      led_mirror_r <= lit;
      led_sense_en_r <= (state_r == ST_MEASURE) & !hold;
      display_r <= light_level_register;
    end
  end

  // ==========================================================
  // Two-wire slave
  // ==========================================================
  wire scl_rise = scl_s_r & ~scl_d_r;
  wire scl_fall = ~scl_s_r & scl_d_r;
  wire bus_start = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  wire bus_stop = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

  reg [2:0] i2_st_r;
  reg [3:0] bit_cnt_r;
  reg [7:0] shift_r;
  reg [7:0] tx_r;
  reg rw_r;
  reg nack_r;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      i2_st_r <= I2_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      rw_r <= 1'b0;
      nack_r <= 1'b0;
      sda_oe_r <= 1'b0;
      sda_out_r <= 1'b0;
      gpio_out_r <= 1'b0;
    end else begin
      // Open drain: data value stays low, only the enable moves
      sda_out_r <= 1'b0;
      if (bus_stop) begin
        i2_st_r <= I2_IDLE;
        sda_oe_r <= 1'b0;
      end else if (bus_start) begin
        i2_st_r <= I2_ADDR;
        bit_cnt_r <= 4'h0;
        sda_oe_r <= 1'b0;
      end else begin
        // No clock stretching: answers settle within the low half of SCL
        case (i2_st_r)
          I2_ADDR, I2_RX: begin
            if (scl_rise) begin
              shift_r <= {shift_r[6:0], sda_s_r};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall && bit_cnt_r == `ALP_I2C_BITS) begin
              if (i2_st_r == I2_RX) begin
                gpio_out_r <= shift_r[0];
                sda_oe_r <= 1'b1;
                i2_st_r <= I2_ACK;
              end else if (shift_r[7:1] == I2C_ADDR) begin
                rw_r <= shift_r[0];
                sda_oe_r <= 1'b1;
                i2_st_r <= I2_ACK;
              end else begin
                i2_st_r <= I2_IDLE;
              end
            end
          end
          I2_ACK: begin
            if (scl_fall) begin
              bit_cnt_r <= rw_r ? 4'h1 : 4'h0;
              // Read: first data bit goes out on the fall that ends the ack
              if (rw_r) begin
                sda_oe_r <= ~light_level_register[7];
                tx_r <= {light_level_register[6:0], 1'b0};
                i2_st_r <= I2_TX;
              end else begin
                sda_oe_r <= 1'b0;
                i2_st_r <= I2_RX;
              end
            end
          end
          I2_TX: begin
            if (scl_fall) begin
              // After eight bits release SDA for the master's ack
              if (bit_cnt_r == `ALP_I2C_BITS) begin
                sda_oe_r <= 1'b0;
                i2_st_r <= I2_MACK;
              end else begin
                sda_oe_r <= ~tx_r[7];
                tx_r <= {tx_r[6:0], 1'b0};
                bit_cnt_r <= bit_cnt_r + 4'h1;
              end
            end
          end
          I2_MACK: begin
            if (scl_rise) begin
              nack_r <= sda_s_r;
            end else if (scl_fall) begin
              // Master ack: send the level again
              if (nack_r) begin
                i2_st_r <= I2_IDLE;
              end else begin
                sda_oe_r <= ~light_level_register[7];
                tx_r <= {light_level_register[6:0], 1'b0};
                bit_cnt_r <= 4'h1;
                i2_st_r <= I2_TX;
              end
            end
          end
          default: begin
            sda_oe_r <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // alp_led_pwm

`default_nettype wire

// File: alp_led_pwm_properties.sv
`timescale 1ns/1ps
`default_nettype none
module alp_led_pwm_props (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Inputs
  input wire osc_in,
  input wire hold_button_n,
  input wire scl_in,
  input wire sda_in,
  // Outputs
  input wire led_sense_en_r,
  input wire led_pwm_r,
  input wire led_mirror_r,
  input wire [7:0] display_r,
  input wire sda_out_r,
  input wire sda_oe_r,
  input wire gpio_out_r
);
  // ==========
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  mirror_copy_a: assert property (
    led_mirror_r == led_pwm_r || led_mirror_r == $past(led_pwm_r)) else $error("mirror off");
  open_drain_a: assert property (sda_out_r == 1'b0) else $error("sda driven high");
  hold_sense_a: assert property (
    !hold_button_n [*4] |-> !led_sense_en_r) else $error("sensing while held");
  hold_level_a: assert property (
    !hold_button_n [*5] |-> $stable(display_r)) else $error("level moved while held");
  level_source_a: assert property (
    $changed(display_r) |-> $past(led_sense_en_r) || $past(led_sense_en_r, 2))
    else $error("level changed outside measure");
  dark_sense_a: assert property (led_sense_en_r |-> !led_pwm_r) else $error("lit while sensing");
  full_lit_a: assert property (
    !hold_button_n [*8] ##0 display_r == 8'hFF |-> led_pwm_r) else $error("full not lit");
  zero_pulse_a: assert property (
    !hold_button_n [*8] ##0 (display_r == 8'h00 && $rose(led_pwm_r)) |=> !led_pwm_r)
    else $error("zero pulse too long");
endmodule // alp_led_pwm_props
bind alp_led_pwm alp_led_pwm_props alp_led_pwm_props_inst (.clk(clk), .nrst(nrst),
  .osc_in(osc_in), .hold_button_n(hold_button_n), .scl_in(scl_in), .sda_in(sda_in),
  .led_sense_en_r(led_sense_en_r), .led_pwm_r(led_pwm_r), .led_mirror_r(led_mirror_r),
  .display_r(display_r), .sda_out_r(sda_out_r), .sda_oe_r(sda_oe_r), .gpio_out_r(gpio_out_r));
`default_nettype wire

// File: alp_i2c_master.sv
`timescale 1ns/1ps
`default_nettype none
module alp_i2c_master (
  // Clock
  input wire logic clk,
  // Bus lines, high means released
  output logic scl,
  output logic sda_drv,
  input wire logic sda_line
);
  // ==========
  // Bit timing, eight clocks a step, three steps a bit
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task q;
    repeat (8) @(posedge clk);
  endtask
  task start;
    sda_drv <= 1'b0;
    q;
    scl <= 1'b0;
    q;
  endtask
  task stop;
    sda_drv <= 1'b0;
    q;
    scl <= 1'b1;
    q;
    sda_drv <= 1'b1;
    q;
  endtask
  // Eight data bits MSB first plus the acknowledge slot
  task bits(input logic [8:0] t, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      sda_drv <= t[i];
      q;
      scl <= 1'b1;
      q;
      r[i] = sda_line;
      scl <= 1'b0;
      q;
    end
  endtask
endmodule // alp_i2c_master
`default_nettype wire

// File: alp_led_pwm_tb.sv
`timescale 1ns/1ps
`default_nettype none
module alp_led_pwm_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic osc_in = 1'b0;
  logic osc_on = 1'b0;
  logic hold_button_n = 1'b1;
  int osc_cnt = 0;
  int osc_per = 4;
  logic led_pwm4, led_mirror4;
  logic [7:0] display4;
  int c4;
  logic scl, sda_drv, sda_in, led_sense_en_r, led_pwm_r, led_mirror_r;
  logic sda_out_r, sda_oe_r, gpio_out_r;
  logic [7:0] display_r;
  logic [8:0] rx;
  int c, m;
  int fails = 0;
  int check_count = 0;
  always #2.5 clk = ~clk;
  // SDA pulled up; either side pulls low
  assign sda_in = sda_drv & ~sda_oe_r;
  always @(posedge clk) begin
    osc_cnt <= (osc_cnt >= osc_per - 1) ? 0 : osc_cnt + 1;
    if (osc_on) osc_in <= (osc_cnt < osc_per / 2);
  end
  // Narrow variant: 4-bit PWM on the same sensor and bus
  alp_led_pwm #(.PWM_W(4), .DWELL_CYC(1100)) alp_led_pwm_narrow_inst (.clk(clk), .nrst(nrst),
    .osc_in(osc_in), .hold_button_n(hold_button_n), .led_sense_en_r(),
    .led_pwm_r(led_pwm4), .led_mirror_r(led_mirror4), .display_r(display4),
    .scl_in(scl), .sda_in(sda_in), .sda_out_r(), .sda_oe_r(),
    .gpio_out_r());
  alp_i2c_master alp_i2c_master_inst (.clk(clk), .scl(scl), .sda_drv(sda_drv), .sda_line(sda_in));
  alp_led_pwm #(.PWM_W(8), .DWELL_CYC(1100)) alp_led_pwm_inst (.clk(clk), .nrst(nrst),
    .osc_in(osc_in), .hold_button_n(hold_button_n), .led_sense_en_r(led_sense_en_r),
    .led_pwm_r(led_pwm_r), .led_mirror_r(led_mirror_r), .display_r(display_r),
    .scl_in(scl), .sda_in(sda_in), .sda_out_r(sda_out_r), .sda_oe_r(sda_oe_r),
    .gpio_out_r(gpio_out_r));
  // ==========
  // Helpers
  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task stop_test;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task wait_sense(input logic v);
    int n;
    n = 0;
    while (led_sense_en_r !== v && n < 20000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20000) begin
      fails++;
      stop_test;
    end
  endtask
  // Hold, then count lit cycles over two full phase cycles
  task held_count;
    hold_button_n <= 1'b0;
    repeat (8) @(posedge clk);
    c = 0;
    m = 0;
    c4 = 0;
    repeat (512) begin
      @(posedge clk);
      c += (led_pwm_r === 1'b1);
      m += (led_mirror_r === 1'b1);
      c4 += (led_pwm4 === 1'b1);
    end
    chk(16'(led_sense_en_r), 16'h0000);
    hold_button_n <= 1'b1;
  endtask
  // ==========
  // Scenarios
  task t_dark;
    wait_sense(1'b1);
    wait_sense(1'b0);
    repeat (4) @(posedge clk);
    chk(16'(display_r), 16'h0000);
    held_count;
    chk(16'(c), 16'h0002);
    chk(16'(m), 16'h0002);
    chk(16'(c4), 16'h0020);
    $display("dark done");
  endtask
  task t_mid;
    osc_per <= 9;
    osc_on <= 1'b1;
    wait_sense(1'b1);
    wait_sense(1'b0);
    repeat (4) @(posedge clk);
    chk(16'(display4[7:4]), 16'h0007);
    held_count;
    chk(16'(c4), 16'h0100);
    chk(16'(c), 16'(m));
    $display("mid done");
  endtask
  task t_bright;
    osc_per <= 4;
    osc_on <= 1'b1;
    wait_sense(1'b1);
    wait_sense(1'b0);
    repeat (4) @(posedge clk);
    chk(16'(display_r), 16'h00FF);
    held_count;
    chk(16'(c), 16'h0200);
    chk(16'(m), 16'h0200);
    chk(16'(c4), 16'h0200);
    $display("bright done");
  endtask
  task t_bus;
    alp_i2c_master_inst.start;
    alp_i2c_master_inst.bits({7'h2A, 1'b1, 1'b1}, rx);
    chk(16'(rx[0]), 16'h0000);
    alp_i2c_master_inst.bits(9'h1FF, rx);
    chk(16'(rx[8:1]), 16'h00FF);
    alp_i2c_master_inst.stop;
    alp_i2c_master_inst.start;
    alp_i2c_master_inst.bits({7'h2A, 1'b0, 1'b1}, rx);
    alp_i2c_master_inst.bits(9'h003, rx);
    chk(16'(rx[0]), 16'h0000);
    alp_i2c_master_inst.stop;
    chk(16'(gpio_out_r), 16'h0001);
    alp_i2c_master_inst.start;
    alp_i2c_master_inst.bits({7'h2B, 1'b1, 1'b1}, rx);
    chk(16'(rx[0]), 16'h0001);
    alp_i2c_master_inst.stop;
    $display("bus done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_dark;
    t_mid;
    t_bright;
    t_bus;
    stop_test;
  end
  initial begin
    #400000;
    fails++;
    stop_test;
  end
endmodule // alp_led_pwm_tb
`default_nettype wire
